/* hdl/expander_config_and_change_detect.sv */
`include "expander_defines.svh"

module expander_config_and_change_detect (
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_in,
	input  wire logic [7:0]                  reg_addr_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	input  wire expander_pkg::reg_byte_type  reg_wdata_in,
	input  wire expander_pkg::port_mask_type port_level_in,
	output logic [7:0]                       reg_rdata_out,
	output logic                             run_out,
	output logic                             detect_en_out,
	output logic                             change_irq_out
);

	////////////////////////////////////////////////////////////////////
	// state held in flip-flops

	logic                        run_reg;
	logic                        detect_reg;
	expander_pkg::port_mask_type mask_reg;
	expander_pkg::port_mask_type level_reg;
	logic                        flag_reg;
	expander_pkg::reg_byte_type  rdata_reg;

	////////////////////////////////////////////////////////////////////
	// next values

	logic                        run_next;
	logic                        detect_next;
	expander_pkg::port_mask_type mask_next;
	expander_pkg::port_mask_type level_next;
	logic                        flag_next;
	expander_pkg::reg_byte_type  rdata_next;

	////////////////////////////////////////////////////////////////////
	// address decode

	wire ctrl_sel;
	wire mask_sel;
	wire ctrl_wr;
	wire mask_wr;
	wire mask_rd;

	assign ctrl_sel = (reg_addr_in == `CTRL_ADDR);
	assign mask_sel = (reg_addr_in == `MASK_ADDR);
	assign ctrl_wr  = reg_wr_in & ctrl_sel;
	assign mask_wr  = reg_wr_in & mask_sel;
	// only a read of the mask register clears the flag
	assign mask_rd  = reg_rd_in & mask_sel;

	////////////////////////////////////////////////////////////////////
	// control register write

	// bit 6 and bits 5..1 of a write are dropped
	assign run_next    = ctrl_wr ? reg_wdata_in[`CTRL_RUN_BIT]
	                             : run_reg;
	// detection is independent of the shutdown bit
	assign detect_next = ctrl_wr ? reg_wdata_in[`CTRL_DETECT_BIT]
	                             : detect_reg;

	////////////////////////////////////////////////////////////////////
	// per-port mask write and change detection

	expander_pkg::port_mask_type port_moved;
	expander_pkg::port_mask_type hit;

	genvar g;
	generate
		for (g = 0; g < `MASK_PORT_COUNT; g++) begin : g_port
			// a 1 lets this port raise the flag
			assign mask_next[g]  = mask_wr ? reg_wdata_in[g]
			                               : mask_reg[g];
			// ports are taken as synchronous, sampled every cycle
			assign level_next[g] = port_level_in[g];
			assign port_moved[g] = port_level_in[g] ^ level_reg[g];
			assign hit[g]        = mask_reg[g] & port_moved[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// change flag

	wire change_seen;
	wire flag_keep;

	assign change_seen = detect_reg & (|hit);
	assign flag_keep   = flag_reg & ~mask_rd;
	// a change in the read cycle beats the clear
	assign flag_next   = change_seen | flag_keep;

	////////////////////////////////////////////////////////////////////
	// read views

	expander_pkg::reg_byte_type ctrl_view;
	expander_pkg::reg_byte_type mask_view;
	expander_pkg::reg_byte_type read_view;

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_ctrl_bit
			if (b == `CTRL_RUN_BIT) begin : g_run
				assign ctrl_view[b] = run_reg;
			end else if (b == `CTRL_DETECT_BIT) begin : g_detect
				assign ctrl_view[b] = detect_reg;
			end else begin : g_zero
				assign ctrl_view[b] = 1'b0;
			end
		end
	endgenerate

	// flag sits in bit 7 above the stored masks
	assign mask_view = {flag_reg, mask_reg};

	// unmapped addresses read as zero
	assign read_view  = ctrl_sel ? ctrl_view :
	                    mask_sel ? mask_view : `UNMAPPED_DATA;
	// data stands until the next read
	assign rdata_next = reg_rd_in ? read_view : rdata_reg;

	////////////////////////////////////////////////////////////////////
	// run bit
	// resets to shutdown

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			run_reg <= `CTRL_RUN_RESET;
		end else begin
			run_reg <= run_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// detect enable bit
	// resets to detection off

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			detect_reg <= `CTRL_DETECT_RESET;
		end else begin
			detect_reg <= detect_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// port masks
	// reset masks every port off

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			mask_reg <= `MASK_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// previous port levels
	// tracks the ports so a change is one cycle wide

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			level_reg <= `LEVEL_RESET;
		end else begin
			level_reg <= level_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// change flag
	// held until a mask read with no new change

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			flag_reg <= `FLAG_RESET;
		end else begin
			flag_reg <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data
	// captured at the read edge, shown one cycle later

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rdata_reg <= `RDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata_out  = rdata_reg;
	assign run_out        = run_reg;
	assign detect_en_out  = detect_reg;
	assign change_irq_out = flag_reg;

endmodule : expander_config_and_change_detect

/* shared/expander_defines.svh */
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH

`define CTRL_ADDR          8'h04
`define MASK_ADDR          8'h06
`define CTRL_RUN_BIT       0
`define CTRL_DETECT_BIT    7
`define CTRL_RESET         8'h00
`define CTRL_RUN_RESET     1'b0
`define CTRL_DETECT_RESET  1'b0
`define FLAG_RESET         1'b0
`define LEVEL_RESET        7'h00
`define RDATA_RESET        8'h00
`define UNMAPPED_DATA      8'h00
`define MASK_RESET         7'h00
`define MASK_FLAG_BIT      7
`define MASK_PORT_BASE     24
`define MASK_PORT_COUNT    7

`endif

/* shared/expander_pkg.sv */
package expander_pkg;
	typedef logic [7:0] reg_byte_type;
	typedef logic [6:0] port_mask_type;
endpackage : expander_pkg

/* tb/expander_chk.sv */
`include "expander_defines.svh"
module expander_chk (
	input wire logic       ref_clk_in,
	input wire logic       rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [6:0] port_level_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       run_out,
	input wire logic       detect_en_out,
	input wire logic       change_irq_out
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge ref_clk_in); endclocking
default disable iff (rst_in);
sequence s_wc;
	reg_wr_in && reg_addr_in == `CTRL_ADDR;
endsequence
sequence s_cr;
	reg_rd_in && reg_addr_in == `CTRL_ADDR;
endsequence
sequence s_mr;
	reg_rd_in && reg_addr_in == `MASK_ADDR;
endsequence
sequence s_or;
	reg_rd_in && reg_addr_in != `CTRL_ADDR && reg_addr_in != `MASK_ADDR;
endsequence
property p_run; s_wc |=> run_out == $past(reg_wdata_in[0]); endproperty
a_run: assert property(p_run) else $error("run");
property p_det; s_wc |=> detect_en_out == $past(reg_wdata_in[7]); endproperty
a_det: assert property(p_det) else $error("det");
property p_rst;
	disable iff (1'b0)
	rst_in |=> !run_out && !detect_en_out && !change_irq_out;
endproperty
a_rst: assert property(p_rst) else $error("reset state");
property p_cview;
	s_cr |=> reg_rdata_out == {detect_en_out, 6'h00, run_out};
endproperty
a_cview: assert property(p_cview) else $error("ctrl read");
property p_fview; s_mr |=> reg_rdata_out[7] == $past(change_irq_out); endproperty
a_fview: assert property(p_fview) else $error("flag read");
property p_clr;
	s_mr ##0 (port_level_in == $past(port_level_in)) |=> !change_irq_out;
endproperty
a_clr: assert property(p_clr) else $error("flag clear");
property p_other; s_or |=> reg_rdata_out == 8'h00; endproperty
a_other: assert property(p_other) else $error("unmapped read");
property p_rise; $rose(change_irq_out) |-> $past(detect_en_out); endproperty
a_rise: assert property(p_rise) else $error("flag w/o detect");
endmodule : expander_chk
bind expander_config_and_change_detect expander_chk expander_chk_inst(.*);

/* tb/host_model.sv */
module host_model(input wire logic c_in,input wire logic [7:0] q_in,
	output logic [7:0] a_out,d_out,output logic w_out,r_out);
timeunit 1ns; timeprecision 1ns;
initial {a_out,d_out,w_out,r_out}=0;
task acc(logic w,logic [7:0] a,d,output logic [7:0] o);
	@(posedge c_in) {w_out,r_out,a_out,d_out}<={w,!w,a,d};
	@(posedge c_in) {w_out,r_out}<=0;
	@(negedge c_in) o=q_in;
endtask:acc
endmodule:host_model

/* tb/expander_config_and_change_detect_tb_top.sv */
module expander_config_and_change_detect_tb_top;
timeunit 1ns; timeprecision 1ns;
logic ref_clk_in=0,rst_in=1,reg_wr_in,reg_rd_in,run_out,detect_en_out;
logic change_irq_out;
logic [7:0] reg_addr_in,reg_wdata_in,reg_rdata_out,v;
logic [6:0] port_level_in=0;
int error_cnt=0,n_compared=0,cyc=0;
always #50 ref_clk_in=~ref_clk_in;
expander_config_and_change_detect expander_config_and_change_detect_inst(.*);
host_model h(.c_in(ref_clk_in),.q_in(reg_rdata_out),.a_out(reg_addr_in),
	.d_out(reg_wdata_in),.w_out(reg_wr_in),.r_out(reg_rd_in));
task chk(string n,logic [7:0] s,e);
	n_compared++;
	if(s!==e) begin
		error_cnt++;
		$display("[ERR] %s exp %h seen %h",n,e,s);
	end
endtask:chk
task print_verdict;
	if(error_cnt==0&&n_compared>0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask:print_verdict
always @(posedge ref_clk_in) if(++cyc>200) begin
	error_cnt++;
	print_verdict;
end
initial begin
	repeat(2) @(posedge ref_clk_in);
	rst_in<=0;
	h.acc(0,8'h04,0,v); chk("ctl",v,0);
	h.acc(1,8'h04,8'hbf,v);
	h.acc(0,8'h04,0,v); chk("ctl",v,8'h81);
	h.acc(1,8'h06,8'hff,v);
	@(posedge ref_clk_in) port_level_in<=7'h40;
	repeat(2) @(negedge ref_clk_in);
	chk("irq",change_irq_out,1);
	h.acc(0,8'h06,0,v); chk("msk",v,8'hff);
	chk("clr",change_irq_out,0);
	h.acc(1,8'h04,8'h80,v); chk("ctl",{detect_en_out,run_out},2);
	@(posedge ref_clk_in) port_level_in<=7'h00;
	repeat(2) @(negedge ref_clk_in);
	chk("irq_sd",change_irq_out,1);
	h.acc(0,8'h06,0,v); chk("msk",v,8'hff);
	h.acc(0,8'h06,0,v); chk("msk2",v,8'h7f);
	h.acc(0,8'h05,0,v); chk("unm",v,0);
	print_verdict;
end
endmodule:expander_config_and_change_detect_tb_top
